// ===== exec_pkg.sv
// Operation
// RULE1 - Table write mode: none, post-inc, post-dec, pre-inc
// RULE2 - Pointer low three bits pick holding register
// RULE3 - Holding registers stage bytes for programming
// RULE4 - Table pointer is 21-bit byte address
// RULE5 - Pointer bit zero selects low/high byte
// RULE6 - Zero test skips next instruction, two cycles
// RULE7 - Skipping two-word instruction costs three cycles
// RULE8 - Test-skip decodes 0110011a, flags untouched
// RULE9 - Access bit zero forces access bank
// RULE10 - XOR literal into working register, N/Z
// RULE11 - XOR file with working register, N/Z
// RULE12 - Destination bit picks working or file
// RULE13 - Table write two cycles, XOR one cycle
package exec_pkg;
	localparam int PTR_W = 21;
	localparam int HOLD_N = 8;
	localparam int HOLD_SEL_W = 3;
	localparam logic [15:0] TABLE_WRITE_MASK = 16'hFFFC;
	localparam logic [15:0] TABLE_WRITE_CODE = 16'h000C;
	localparam logic [15:0] TST_MASK = 16'hFE00;
	localparam logic [15:0] TST_CODE = 16'h6600;
	localparam logic [15:0] XORL_MASK = 16'hFF00;
	localparam logic [15:0] XORL_CODE = 16'h0A00;
	localparam logic [15:0] XORF_MASK = 16'hFC00;
	localparam logic [15:0] XORF_CODE = 16'h1800;
	localparam int BIT_D = 9;
	localparam int BIT_A = 8;
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_POSTINC = 2'h1;
	localparam logic [1:0] MODE_POSTDEC = 2'h2;
	localparam logic [1:0] MODE_PREINC = 2'h3;
	localparam logic [3:0] ACCESS_BANK = 4'h0;
	localparam logic [3:0] ACCESS_BANK_HI = 4'hF;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam int FADDR_W = 8;
	localparam int MODE_W = 2;
	localparam logic [7:0] HOLD_ERASED = 8'hFF;
	typedef enum logic [1:0] {ST_RUN = 2'h0, ST_TBL2 = 2'h1, ST_SKIP1 = 2'h3, ST_SKIP2 = 2'h2} state_t;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic we;
	} file_req_t;
	typedef struct packed {
		logic n;
		logic z;
		logic we;
	} flag_upd_t;
endpackage

// ===== hold_regs.sv
module hold_regs
	import exec_pkg::*;
#(
	parameter int N = HOLD_N
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic we,
	input wire logic [HOLD_SEL_W-1:0] sel,
	input wire logic [7:0] wdata,
	output logic [N*8-1:0] hold_flat
);
	logic [7:0] hold_reg [N];
	logic [7:0] hold_next [N];
	// Erased-state default so partly written blocks program as blank
	genvar g;
	for (g = 0; g < N; g++) begin : g_hold
		always_comb begin
			hold_next[g] = hold_reg[g];
			if (we && sel == HOLD_SEL_W'(g)) begin
				hold_next[g] = wdata; // see RULE2
			end
		end
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				hold_reg[g] <= HOLD_ERASED;
			end else if (ce) begin
				hold_reg[g] <= hold_next[g];
			end
		end
		assign hold_flat[g*8 +: 8] = hold_reg[g]; // see RULE3
	end
endmodule

// ===== exec_unit.sv
module exec_unit
	import exec_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [15:0] instr,
	input wire logic instr_valid,
	input wire logic next_two_word,
	input wire logic [7:0] w_in,
	input wire logic [7:0] file_rdata,
	input wire logic [3:0] bank_select_register,
	input wire logic [7:0] table_latch,
	input wire logic [PTR_W-1:0] ptr_load,
	input wire logic ptr_load_en,
	output logic [11:0] file_raddr,
	output logic busy,
	output logic discard,
	output file_req_t file_wr,
	output flag_upd_t flag_wr,
	output logic [7:0] w_out,
	output logic w_we,
	output logic [PTR_W-1:0] table_pointer,
	output logic byte_high,
	output logic [HOLD_N*8-1:0] hold_flat
);
	state_t state_reg, state_next;
	logic [MODE_W-1:0] mode_reg, mode_next;
	logic [PTR_W-1:0] ptr_reg, ptr_next;
	logic [PTR_W-1:0] ptr_plus, ptr_minus;
	file_req_t file_reg, file_next;
	flag_upd_t flag_reg, flag_next;
	logic [7:0] w_reg, w_next;
	logic w_we_reg, w_we_next;
	logic hold_we;
	logic [7:0] result;
	logic [FADDR_W-1:0] op_field;
	logic [MODE_W-1:0] mode_field;
	logic idle;
	logic take;
	logic is_table_write, is_tst, is_xorl, is_xorf;
	logic any_op;
	logic xor_hit;
	logic skip_hit;
	logic ptr_post_up, ptr_post_down;

	// Fields of the instruction word
	assign op_field = instr[FADDR_W-1:0];
	assign mode_field = instr[MODE_W-1:0];

	// Busy cycles take no instruction; only file_raddr still follows the bus
	assign idle = (state_reg == ST_RUN);
	assign take = instr_valid && idle;

	// Opcode decode; the four patterns are disjoint, so one fires at most
	// Unknown opcodes decode to nothing and pass as no-ops
	always_comb begin
		is_table_write = take && ((instr & TABLE_WRITE_MASK) == TABLE_WRITE_CODE); // see RULE1
		is_tst = take && ((instr & TST_MASK) == TST_CODE); // see RULE8
		is_xorl = take && ((instr & XORL_MASK) == XORL_CODE); // see RULE10
		is_xorf = take && ((instr & XORF_MASK) == XORF_CODE); // see RULE11
		any_op = is_table_write || is_tst || is_xorl || is_xorf;
	end

	// Either XOR form produces status and a result
	assign xor_hit = is_xorl || is_xorf;

	// Access bank splits low GPRs and high SFRs
	always_comb begin
		if (!instr[BIT_A]) begin
			// Common window reachable without touching the bank select
			if (op_field < ACCESS_SPLIT) begin
				file_raddr = {ACCESS_BANK, op_field}; // see RULE9
			end else begin
				file_raddr = {ACCESS_BANK_HI, op_field}; // see RULE9
			end
		end else begin
			file_raddr = {bank_select_register, op_field}; // see RULE9
		end
	end

	// One shared XOR; the literal sits where a file address would
	always_comb begin
		if (is_xorl) begin
			result = w_in ^ op_field; // see RULE10
		end else begin
			result = w_in ^ file_rdata; // see RULE11
		end
	end

	// A zero test only matters once it is really taken
	assign skip_hit = is_tst && (file_rdata == 8'h00); // see RULE6

	// Sequencer next state; table write and skip both stretch the instruction
	always_comb begin
		state_next = state_reg;
		mode_next = mode_reg;
		hold_we = 1'h0;
		unique case (state_reg)
			ST_RUN: begin
				if (is_table_write) begin
					mode_next = mode_field; // see RULE1
					state_next = ST_TBL2; // see RULE13
				end else if (skip_hit) begin
					// Operand word of a two-word victim must be dropped too
					if (next_two_word) begin
						state_next = ST_SKIP1; // see RULE7
					end else begin
						state_next = ST_SKIP2; // see RULE6
					end
				end
			end
			ST_TBL2: begin
				// Latch byte goes to the slot the pointer names now
				hold_we = 1'h1; // see RULE2 RULE13
				state_next = ST_RUN;
			end
			ST_SKIP1: begin
				state_next = ST_SKIP2; // see RULE7
			end
			ST_SKIP2: begin
				state_next = ST_RUN; // see RULE6
			end
		endcase
	end

	// Sequencer registers, frozen while the enable is low
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= ST_RUN;
			mode_reg <= MODE_NONE;
		end else if (ce) begin
			state_reg <= state_next;
			mode_reg <= mode_next;
		end
	end

	// Pointer wraps at either end of the byte space, no saturation
	assign ptr_plus = ptr_reg + PTR_W'(1); // see RULE4
	assign ptr_minus = ptr_reg - PTR_W'(1); // see RULE4

	// Post modes move the pointer only in the writing cycle
	assign ptr_post_up = (state_reg == ST_TBL2) && (mode_reg == MODE_POSTINC);
	assign ptr_post_down = (state_reg == ST_TBL2) && (mode_reg == MODE_POSTDEC);

	// Pointer next value; pre-increment lands early so the write sees the new slot
	always_comb begin
		ptr_next = ptr_reg;
		if (is_table_write && mode_field == MODE_PREINC) begin
			ptr_next = ptr_plus; // see RULE1
		end else if (ptr_post_up) begin
			ptr_next = ptr_plus; // see RULE1
		end else if (ptr_post_down) begin
			ptr_next = ptr_minus; // see RULE1
		end else if (idle && ptr_load_en && !any_op) begin
			// Loads yield to any decoded instruction, so they never race a write
			ptr_next = ptr_load;
		end
	end

	// Pointer register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ptr_reg <= '0;
		end else if (ce) begin
			ptr_reg <= ptr_next;
		end
	end

	// Write-back next values; every pulse clears itself after one cycle
	always_comb begin
		file_next = '0;
		flag_next = '0;
		w_next = w_reg;
		w_we_next = 1'h0;
		if (xor_hit) begin
			// Only N and Z move; other status bits are not ours to touch
			flag_next.we = 1'h1; // see RULE10 RULE11
			flag_next.n = result[7];
			flag_next.z = (result == 8'h00);
			if (is_xorf && instr[BIT_D]) begin
				file_next.we = 1'h1; // see RULE12
				file_next.addr = file_raddr;
				file_next.wdata = result;
			end else begin
				w_we_next = 1'h1; // see RULE12
				w_next = result;
			end
		end
	end

	// Write-back registers; W copy holds its last value between pulses
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			file_reg <= '0;
			flag_reg <= '0;
			w_reg <= 8'h00;
			w_we_reg <= 1'h0;
		end else if (ce) begin
			file_reg <= file_next;
			flag_reg <= flag_next;
			w_reg <= w_next;
			w_we_reg <= w_we_next;
		end
	end

	hold_regs #(.N(HOLD_N)) u_hold (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.we(hold_we),
		.sel(ptr_reg[HOLD_SEL_W-1:0]), // see RULE2
		.wdata(table_latch),
		.hold_flat(hold_flat)
	);

	// Pointer is byte address; bit 0 picks word half
	assign table_pointer = ptr_reg; // see RULE4
	assign byte_high = ptr_reg[0]; // see RULE5
	assign busy = (state_reg != ST_RUN);
	assign discard = (state_reg == ST_SKIP1) || (state_reg == ST_SKIP2); // see RULE6
	assign file_wr = file_reg;
	assign flag_wr = flag_reg;
	assign w_out = w_reg;
	assign w_we = w_we_reg;
endmodule

// ===== exec_sva.sv
module exec_sva import exec_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [15:0] instr,
	input wire logic instr_valid,
	input wire logic next_two_word,
	input wire logic [7:0] w_in,
	input wire logic [7:0] file_rdata,
	input wire logic [3:0] bank_select_register,
	input wire logic [7:0] table_latch,
	input wire logic [11:0] file_raddr,
	input wire logic busy,
	input wire logic discard,
	input wire file_req_t file_wr,
	input wire flag_upd_t flag_wr,
	input wire logic [7:0] w_out,
	input wire logic w_we,
	input wire logic [PTR_W-1:0] table_pointer,
	input wire logic [HOLD_N*8-1:0] hold_flat
);
	timeunit 1ns;
	timeprecision 100ps;
	// Decode of the taken instruction
	wire t = ce && instr_valid && !busy;
	wire xl = (instr & XORL_MASK) == XORL_CODE;
	wire xf = (instr & XORF_MASK) == XORF_CODE;
	wire ts = (instr & TST_MASK) == TST_CODE;
	wire tw = (instr & TABLE_WRITE_MASK) == TABLE_WRITE_CODE;
	wire [FADDR_W-1:0] lit = instr[FADDR_W-1:0];
	wire [HOLD_SEL_W-1:0] slot = table_pointer[HOLD_SEL_W-1:0];
	wire z = file_rdata == 8'h00;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_xl; t && xl |=> w_we && flag_wr.we && w_out == ($past(w_in) ^ $past(lit)); endproperty
	a_xl: assert property (p_xl) else $error("xl");
	property p_x1;
		t && xf && instr[BIT_D] |=> file_wr.we && !w_we && file_wr.addr == $past(file_raddr)
			&& file_wr.wdata == ($past(w_in) ^ $past(file_rdata)) && flag_wr.z == (file_wr.wdata == 8'h00);
	endproperty
	a_x1: assert property (p_x1) else $error("x1");
	property p_x0; t && xf && !instr[BIT_D] |=> w_we && !file_wr.we && w_out == ($past(w_in) ^ $past(file_rdata)); endproperty
	a_x0: assert property (p_x0) else $error("x0");
	property p_ac; (xf || ts) && !instr[BIT_A] && instr[7:0] < ACCESS_SPLIT |-> file_raddr[11:8] == ACCESS_BANK; endproperty
	a_ac: assert property (p_ac) else $error("ac");
	property p_ab; instr[BIT_A] |-> file_raddr == {bank_select_register, lit}; endproperty
	a_ab: assert property (p_ab) else $error("ab");
	// Skip holds off new work for exactly the nop cycles
	property p_s1; t && ts && z && !next_two_word |=> discard && !flag_wr.we ##1 !busy; endproperty
	a_s1: assert property (p_s1) else $error("s1");
	property p_s2; t && ts && z && next_two_word |=> discard [*2] ##1 !busy; endproperty
	a_s2: assert property (p_s2) else $error("s2");
	// Holding write lands at the second edge and is checked two edges after that
	property p_tw; t && tw |=> busy ##1 !busy ##1 hold_flat[8*$past(slot, 2) +: 8] == $past(table_latch); endproperty
	a_tw: assert property (p_tw) else $error("tw");
	property p_pi; t && tw && instr[1:0] == MODE_PREINC |=> table_pointer == PTR_W'($past(table_pointer) + 1); endproperty
	a_pi: assert property (p_pi) else $error("pi");
	cover property (t && tw);
	cover property (t && ts && z && next_two_word);
	cover property (t && xf);
endmodule

// ===== table_write_xor_test_exec_tb.sv
module table_write_xor_test_exec_tb import exec_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 0, rst = 1, ce = 1, instr_valid = 0, next_two_word = 0, ptr_load_en = 0;
	logic busy, discard, w_we, byte_high;
	logic [15:0] instr = 0, op;
	logic [7:0] w_in = 0, file_rdata = 0, table_latch = 0, w_out, w, k, e;
	logic [3:0] bank_select_register = 0;
	logic [11:0] file_raddr;
	logic [PTR_W-1:0] ptr_load = 0, table_pointer, p, d;
	logic [63:0] hold_flat;
	file_req_t file_wr;
	flag_upd_t flag_wr;
	int errors = 0, samples_checked = 0;
	always #12.5 ref_clk = ~ref_clk;
	exec_unit uut (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.instr(instr),
		.instr_valid(instr_valid),
		.next_two_word(next_two_word),
		.w_in(w_in),
		.file_rdata(file_rdata),
		.bank_select_register(bank_select_register),
		.table_latch(table_latch),
		.ptr_load(ptr_load),
		.ptr_load_en(ptr_load_en),
		.file_raddr(file_raddr),
		.busy(busy),
		.discard(discard),
		.file_wr(file_wr),
		.flag_wr(flag_wr),
		.w_out(w_out),
		.w_we(w_we),
		.table_pointer(table_pointer),
		.byte_high(byte_high),
		.hold_flat(hold_flat)
	);
	function logic [7:0] xr(input logic [7:0] a, b);
		return a ^ b;
	endfunction
	// Expected file address: access bit low means the fixed split window
	function logic [11:0] fa(input logic [15:0] o, input logic [3:0] b);
		if (o[BIT_A])
			return {b, o[7:0]};
		if (o[7:0] < ACCESS_SPLIT)
			return {ACCESS_BANK, o[7:0]};
		return {ACCESS_BANK_HI, o[7:0]};
	endfunction
	task chk(input logic [20:0] g, x);
		samples_checked++;
		if (g !== x) begin
			errors++;
			$display("wrong value %0t got %h exp %h", $time, g, x);
		end
	endtask
	// One instruction, taken at the second edge
	task go(input logic [15:0] op, input logic [7:0] a, f, input logic two, input logic [7:0] lat);
		@(posedge ref_clk);
		instr <= op;
		instr_valid <= 1;
		w_in <= a;
		file_rdata <= f;
		next_two_word <= two;
		table_latch <= lat;
		bank_select_register <= 4'($urandom);
		@(posedge ref_clk);
		instr_valid <= 0;
		#1;
	endtask
	task complete_run;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Far beyond the 85 or so cycles the tests need
	initial begin
		#50us;
		errors++;
		complete_run;
	end
	initial begin
		void'($urandom(32'hF185));
		repeat (16) @(posedge ref_clk);
		rst <= 0;
		ptr_load <= PTR_W'($urandom);
		ptr_load_en <= 1;
		@(posedge ref_clk);
		ptr_load_en <= 0;
		p = ptr_load;
		#1;
		chk(hold_flat[7:0], 8'hFF);
		for (int i = 0; i < 8; i++) begin
			k = 8'($urandom);
			go({14'h0003, i[1:0]}, 0, 0, 0, k);
			chk(busy, 1);
			@(posedge ref_clk);
			#1;
			if (i[1:0] == MODE_PREINC) p = p + 1;
			chk(hold_flat[8*p[2:0] +: 8], k);
			if (i[1:0] == MODE_POSTINC) p = p + 1;
			if (i[1:0] == MODE_POSTDEC) p = p - 1;
			chk(table_pointer, p);
			chk(byte_high, p[0]);
		end
		$display("table write done");
		for (int i = 0; i < 12; i++) begin
			w = 8'($urandom);
			k = (i == 0) ? w : 8'($urandom);
			op = (i % 3 == 0) ? {8'h0A, k} : {6'h06, i % 3 == 2, 1'($urandom), 8'($urandom)};
			go(op, w, k, 0, 0);
			e = xr(w, k);
			chk((i % 3 == 2) ? file_wr.wdata : w_out, e);
			chk(flag_wr.z, e == 0);
			chk(flag_wr.n, e[7]);
			chk(flag_wr.we, 1);
			chk(file_wr.we, i % 3 == 2);
			chk(w_we, i % 3 != 2);
			if (i % 3 == 2) chk(file_wr.addr, fa(op, bank_select_register));
		end
		$display("xor done");
		for (int i = 0; i < 4; i++) begin
			go({7'h33, 1'($urandom), 8'($urandom)}, 0, i[1] ? 8'($urandom) | 8'h01 : 0, i[0], 0);
			d = 0;
			repeat (3) begin
				d = d + discard;
				@(posedge ref_clk);
				#1;
			end
			chk(d, i[1] ? 0 : 1 + i[0]);
		end
		$display("skip test done");
		complete_run;
	end
endmodule
bind exec_unit exec_sva u_sva (
	.ref_clk(ref_clk),
	.rst(rst),
	.ce(ce),
	.instr(instr),
	.instr_valid(instr_valid),
	.next_two_word(next_two_word),
	.w_in(w_in),
	.file_rdata(file_rdata),
	.bank_select_register(bank_select_register),
	.table_latch(table_latch),
	.file_raddr(file_raddr),
	.busy(busy),
	.discard(discard),
	.file_wr(file_wr),
	.flag_wr(flag_wr),
	.w_out(w_out),
	.w_we(w_we),
	.table_pointer(table_pointer),
	.hold_flat(hold_flat)
);
